// >>> logic/sdb_gfx_burst.sv
// Read and write burst data path of the memory device, with APB registers
`timescale 1ns/100ps
module sdb_gfx_burst import sdb_pkg::*; #(
    parameter int MEM_DEPTH = MEM_WORDS
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Command link
    input wire logic LINK_CLK,
    input wire logic CKE,
    input wire logic CS_N,
    input wire logic RAS_N,
    input wire logic CAS_N,
    input wire logic WE_N,
    input wire logic [BA_W-1:0] BA,
    input wire logic [ADDR_W-1:0] CMD_ADDR,
    // Data pins and strobes
    input wire logic [DQ_W-1:0] DATA_PIN_SENSE,
    output logic [DQ_W-1:0] DATA_PIN_DRIVE,
    output logic [LANES-1:0] DATA_PIN_OE_N,
    output logic [LANES-1:0] READ_DATA_STROBE,
    output logic [LANES-1:0] READ_DATA_STROBE_OE_N,
    input wire logic [LANES-1:0] WRITE_DATA_STROBE,
    // Termination control
    output logic TERM_EN
);
    sdb_link_if lnk();

    sdb_link_rx u_rx (
        .clk(CLK),
        .rst(RST),
        .lck(LINK_CLK),
        .cke(CKE),
        .cs_n(CS_N),
        .ras_n(RAS_N),
        .cas_n(CAS_N),
        .we_n(WE_N),
        .ba(BA),
        .addr(CMD_ADDR),
        .write_data_strobe(WRITE_DATA_STROBE),
        .dq(DATA_PIN_SENSE),
        .lnk(lnk)
    );

    logic [7:0] mem [MEM_DEPTH][LANES];
    logic [3:0] cfg_cl_r;
    logic [3:0] cfg_wl_r;
    logic cfg_bl8_r;
    logic [7:0] ras_min_r;
    logic [15:0] rd_cnt_r;
    logic [15:0] wr_cnt_r;
    logic [15:0] ap_cnt_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic [3:0] bl;
    logic [COL_W-1:0] cmd_col;
    logic cmd_ap;
    logic [3:0] cl_idx;
    logic [3:0] wl_idx;

    assign bl = cfg_bl8_r ? BL8 : BL4;
    assign cmd_col = lnk.addr[COL_W-1:0];
    assign cmd_ap = lnk.addr[AUTO_PRECHARGE_SELECT_BIT];
    assign cl_idx = (cfg_cl_r == 4'h0) ? 4'h0 : cfg_cl_r - 4'h1;
    assign wl_idx = (cfg_wl_r == 4'h0) ? 4'h0 : cfg_wl_r - 4'h1;

    // Latency delay lines, one slot per link cycle
    logic [LAT_DEPTH-1:0] rd_pipe_v_r;
    logic [BA_W-1:0] rd_pipe_ba_r [LAT_DEPTH];
    logic [COL_W-1:0] rd_pipe_col_r [LAT_DEPTH];
    logic [LAT_DEPTH-1:0] rd_pipe_ap_r;
    logic [LAT_DEPTH-1:0] wr_pipe_v_r;
    logic [BA_W-1:0] wr_pipe_ba_r [LAT_DEPTH];
    logic [COL_W-1:0] wr_pipe_col_r [LAT_DEPTH];
    logic [LAT_DEPTH-1:0] wr_pipe_ap_r;

    always_ff @(posedge CLK) begin
        if (RST) begin
            rd_pipe_v_r <= '0;
            rd_pipe_ap_r <= '0;
            wr_pipe_v_r <= '0;
            wr_pipe_ap_r <= '0;
            for (int i = 0; i < LAT_DEPTH; i++) begin
                rd_pipe_ba_r[i] <= '0;
                rd_pipe_col_r[i] <= '0;
                wr_pipe_ba_r[i] <= '0;
                wr_pipe_col_r[i] <= '0;
            end
        end else if (lnk.lck_rise) begin
            rd_pipe_v_r <= {1'b0, rd_pipe_v_r[LAT_DEPTH-1:1]};
            rd_pipe_ap_r <= {1'b0, rd_pipe_ap_r[LAT_DEPTH-1:1]};
            wr_pipe_v_r <= {1'b0, wr_pipe_v_r[LAT_DEPTH-1:1]};
            wr_pipe_ap_r <= {1'b0, wr_pipe_ap_r[LAT_DEPTH-1:1]};
            for (int i = 0; i < LAT_DEPTH - 1; i++) begin
                rd_pipe_ba_r[i] <= rd_pipe_ba_r[i+1];
                rd_pipe_col_r[i] <= rd_pipe_col_r[i+1];
                wr_pipe_ba_r[i] <= wr_pipe_ba_r[i+1];
                wr_pipe_col_r[i] <= wr_pipe_col_r[i+1];
            end
            if (lnk.cmd == CMD_READ) begin
                rd_pipe_v_r[cl_idx] <= 1'b1;
                rd_pipe_ba_r[cl_idx] <= lnk.ba;
                rd_pipe_col_r[cl_idx] <= cmd_col;
                rd_pipe_ap_r[cl_idx] <= cmd_ap;
            end
            if (lnk.cmd == CMD_WRITE) begin
                wr_pipe_v_r[wl_idx] <= 1'b1;
                wr_pipe_ba_r[wl_idx] <= lnk.ba;
                wr_pipe_col_r[wl_idx] <= cmd_col;
                wr_pipe_ap_r[wl_idx] <= cmd_ap;
            end
        end
    end

    // Read burst engine, stepping on both link edges
    sdb_rd_state_t rd_state_r;
    logic [2:0] rd_elem_r;
    logic [BA_W-1:0] rd_ba_r;
    logic [COL_W-1:0] rd_col_r;
    logic rd_ap_r;
    logic rd_start;
    logic rd_last;
    logic rd_done;
    logic [2:0] rd_elem_nxt;
    logic [BA_W-1:0] rd_ba_sel;
    logic [COL_W-1:0] rd_col_sel;
    logic [DQ_W-1:0] rd_word;
    logic [BA_W+COL_W-1:0] rd_addr;

    assign rd_start = lnk.lck_rise && rd_pipe_v_r[0];
    assign rd_last = ({1'b0, rd_elem_r} == bl - 4'h1);
    assign rd_done = lnk.lck_rise && (rd_state_r == RD_BURST) && rd_last;
    assign rd_elem_nxt = rd_start ? 3'h0 : rd_elem_r + 3'h1;
    assign rd_ba_sel = rd_start ? rd_pipe_ba_r[0] : rd_ba_r;
    assign rd_col_sel = rd_start ? rd_pipe_col_r[0] : rd_col_r;
    assign rd_addr = {rd_ba_sel, sdb_burst_col(rd_col_sel, rd_elem_nxt, cfg_bl8_r)};

    always_comb begin
        rd_word = '0;
        for (int l = 0; l < LANES; l++) begin
            rd_word[l*8 +: 8] = mem[rd_addr][l];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            rd_state_r <= RD_IDLE;
            rd_elem_r <= 3'h0;
            rd_ba_r <= '0;
            rd_col_r <= '0;
            rd_ap_r <= 1'b0;
            READ_DATA_STROBE <= '0;
            READ_DATA_STROBE_OE_N <= '1;
            DATA_PIN_DRIVE <= '0;
            DATA_PIN_OE_N <= '1;
        end else begin
            case (rd_state_r)
                RD_IDLE: begin
                    if (lnk.lck_fall && rd_pipe_v_r[0]) begin
                        rd_state_r <= RD_PRE;
                        READ_DATA_STROBE <= '1;
                        READ_DATA_STROBE_OE_N <= '0;
                    end
                end
                RD_PRE: begin
                    if (rd_start) begin
                        rd_state_r <= RD_BURST;
                        rd_elem_r <= 3'h0;
                        rd_ba_r <= rd_pipe_ba_r[0];
                        rd_col_r <= rd_pipe_col_r[0];
                        rd_ap_r <= rd_pipe_ap_r[0];
                        READ_DATA_STROBE <= '0;
                        DATA_PIN_DRIVE <= rd_word;
                        DATA_PIN_OE_N <= '0;
                    end
                end
                RD_BURST: begin
                    if (rd_start) begin
                        rd_elem_r <= 3'h0;
                        rd_ba_r <= rd_pipe_ba_r[0];
                        rd_col_r <= rd_pipe_col_r[0];
                        rd_ap_r <= rd_pipe_ap_r[0];
                        READ_DATA_STROBE <= '0;
                        DATA_PIN_DRIVE <= rd_word;
                    end else if (rd_done) begin
                        rd_state_r <= RD_IDLE;
                        READ_DATA_STROBE <= '0;
                        READ_DATA_STROBE_OE_N <= '1;
                        DATA_PIN_OE_N <= '1;
                    end else if (lnk.lck_rise || lnk.lck_fall) begin
                        rd_elem_r <= rd_elem_nxt;
                        READ_DATA_STROBE <= {LANES{lnk.lck_fall}};
                        DATA_PIN_DRIVE <= rd_word;
                    end
                end
                default: begin
                    rd_state_r <= RD_IDLE;
                end
            endcase
        end
    end

    // Write capture, one element counter per byte lane
    logic [LANES-1:0] wr_act_r;
    logic [3:0] wr_lcnt_r [LANES];
    logic [BA_W-1:0] wr_ba_r;
    logic [COL_W-1:0] wr_col_r;
    logic wr_ap_r;
    logic wr_arm;
    logic wr_done;

    assign wr_arm = lnk.lck_rise && wr_pipe_v_r[0];
    assign wr_done = wr_act_r[0] && (wr_lcnt_r[0] == bl - 4'h1) &&
                     (lnk.write_data_strobe_rise[0] || lnk.write_data_strobe_fall[0]);

    always_ff @(posedge CLK) begin
        if (RST) begin
            wr_act_r <= '0;
            wr_ba_r <= '0;
            wr_col_r <= '0;
            wr_ap_r <= 1'b0;
            for (int l = 0; l < LANES; l++) begin
                wr_lcnt_r[l] <= 4'h0;
            end
        end else begin
            if (wr_arm) begin
                wr_ba_r <= wr_pipe_ba_r[0];
                wr_col_r <= wr_pipe_col_r[0];
                wr_ap_r <= wr_pipe_ap_r[0];
            end
            for (int l = 0; l < LANES; l++) begin
                if (wr_arm) begin
                    wr_act_r[l] <= 1'b1;
                    wr_lcnt_r[l] <= 4'h0;
                    if (lnk.write_data_strobe_rise[l]) begin
                        mem[{wr_pipe_ba_r[0], wr_pipe_col_r[0]}][l] <= lnk.dq[l*8 +: 8];
                        wr_lcnt_r[l] <= 4'h1;
                    end
                end else if (wr_act_r[l] && (lnk.write_data_strobe_rise[l] ||
                             (lnk.write_data_strobe_fall[l] && wr_lcnt_r[l] != 4'h0))) begin
                    mem[{wr_ba_r, sdb_burst_col(wr_col_r, wr_lcnt_r[l][2:0], cfg_bl8_r)}][l]
                        <= lnk.dq[l*8 +: 8];
                    wr_lcnt_r[l] <= wr_lcnt_r[l] + 4'h1;
                    if (wr_lcnt_r[l] == bl - 4'h1) begin
                        wr_act_r[l] <= 1'b0;
                    end
                end
            end
        end
    end

    // Bank open state, row-active timers and auto precharge
    logic [NBANK-1:0] bank_open_r;
    logic [NBANK-1:0] ap_pend_r;
    logic [7:0] ras_tmr_r [NBANK];

    always_ff @(posedge CLK) begin
        if (RST) begin
            bank_open_r <= '0;
            ap_pend_r <= '0;
            ap_cnt_r <= 16'h0000;
            for (int b = 0; b < NBANK; b++) begin
                ras_tmr_r[b] <= 8'h00;
            end
        end else begin
            for (int b = 0; b < NBANK; b++) begin
                if (lnk.lck_rise && bank_open_r[b] && ras_tmr_r[b] != 8'hff) begin
                    ras_tmr_r[b] <= ras_tmr_r[b] + 8'h01;
                end
                if (ap_pend_r[b] && ras_tmr_r[b] >= ras_min_r) begin
                    bank_open_r[b] <= 1'b0;
                    ap_pend_r[b] <= 1'b0;
                end
            end
            if (rd_done && rd_ap_r) begin
                ap_pend_r[rd_ba_r] <= 1'b1;
            end
            if (wr_done && wr_ap_r) begin
                bank_open_r[wr_ba_r] <= 1'b0;
            end
            if (lnk.lck_rise && lnk.cmd == CMD_PRE) begin
                if (cmd_ap) begin
                    bank_open_r <= '0;
                end else begin
                    bank_open_r[lnk.ba] <= 1'b0;
                end
            end
            if (lnk.lck_rise && lnk.cmd == CMD_ACT) begin
                bank_open_r[lnk.ba] <= 1'b1;
                ras_tmr_r[lnk.ba] <= 8'h00;
            end
            if ((wr_done && wr_ap_r) || (|(ap_pend_r & ras_done_vec()))) begin
                ap_cnt_r <= ap_cnt_r + 16'h0001;
            end
        end
    end

    function automatic logic [NBANK-1:0] ras_done_vec();
        logic [NBANK-1:0] v;
        v = '0;
        for (int b = 0; b < NBANK; b++) begin
            v[b] = (ras_tmr_r[b] >= ras_min_r);
        end
        return v;
    endfunction

    // Termination off from read command until the burst has ended
    always_ff @(posedge CLK) begin
        if (RST) begin
            TERM_EN <= 1'b1;
        end else begin
            TERM_EN <= !((|rd_pipe_v_r) || rd_state_r != RD_IDLE ||
                         (lnk.lck_rise && lnk.cmd == CMD_READ));
        end
    end

    // APB slave, no wait states, ready in the first access cycle
    function automatic logic apb_mapped(input logic [7:0] a);
        return a == OFS_CFG || a == OFS_RAS || a == OFS_STAT ||
               a == OFS_RDCNT || a == OFS_WRCNT || a == OFS_APCNT;
    endfunction

    always_ff @(posedge CLK) begin
        if (RST) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            cfg_cl_r <= CL_RST;
            cfg_wl_r <= WL_RST;
            cfg_bl8_r <= 1'b0;
            ras_min_r <= RAS_RST;
        end else begin
            pready_r <= PSEL && !PENABLE && !pready_r;
            pslverr_r <= PSEL && !PENABLE && !apb_mapped(PADDR);
            prdata_r <= 32'h0000_0000;
            if (PSEL && !PENABLE && !PWRITE) begin
                if (PADDR == OFS_CFG) begin
                    prdata_r <= {23'h0, cfg_bl8_r, cfg_wl_r, cfg_cl_r};
                end else if (PADDR == OFS_RAS) begin
                    prdata_r <= {24'h0, ras_min_r};
                end else if (PADDR == OFS_STAT) begin
                    prdata_r <= {25'h0, TERM_EN, |wr_act_r, rd_state_r != RD_IDLE,
                                 bank_open_r};
                end else if (PADDR == OFS_RDCNT) begin
                    prdata_r <= {16'h0, rd_cnt_r};
                end else if (PADDR == OFS_WRCNT) begin
                    prdata_r <= {16'h0, wr_cnt_r};
                end else if (PADDR == OFS_APCNT) begin
                    prdata_r <= {16'h0, ap_cnt_r};
                end
            end
            if (PSEL && PENABLE && pready_r && PWRITE) begin
                if (PADDR == OFS_CFG) begin
                    cfg_cl_r <= PWDATA[CFG_CL_LSB +: 4];
                    cfg_wl_r <= PWDATA[CFG_WL_LSB +: 4];
                    cfg_bl8_r <= PWDATA[CFG_BL8_BIT];
                end else if (PADDR == OFS_RAS) begin
                    ras_min_r <= PWDATA[7:0];
                end
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            rd_cnt_r <= 16'h0000;
            wr_cnt_r <= 16'h0000;
        end else begin
            if (rd_done) begin
                rd_cnt_r <= rd_cnt_r + 16'h0001;
            end
            if (wr_done) begin
                wr_cnt_r <= wr_cnt_r + 16'h0001;
            end
        end
    end

    assign PREADY = pready_r;
    assign PSLVERR = pslverr_r;
    assign PRDATA = prdata_r;
endmodule

// >>> logic/sdb_link_if.sv
// Synchronised link events passed from the front end to the core
`timescale 1ns/100ps
interface sdb_link_if;
    import sdb_pkg::*;
    logic lck_rise;
    logic lck_fall;
    sdb_cmd_t cmd;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] write_data_strobe_rise;
    logic [LANES-1:0] write_data_strobe_fall;
    logic [DQ_W-1:0] dq;
    modport rx (output lck_rise, lck_fall, cmd, ba, addr, write_data_strobe_rise, write_data_strobe_fall, dq);
    modport core (input lck_rise, lck_fall, cmd, ba, addr, write_data_strobe_rise, write_data_strobe_fall, dq);
endinterface

// >>> logic/sdb_link_rx.sv
// Pin synchroniser, filter and edge finder for the link side
`timescale 1ns/100ps
module sdb_link_rx import sdb_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Raw pins
    input wire logic lck,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [BA_W-1:0] ba,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [LANES-1:0] write_data_strobe,
    input wire logic [DQ_W-1:0] dq,
    // Filtered events
    sdb_link_if.rx lnk
);
    logic [RAW_W-1:0] raw;
    logic [RAW_W-1:0] s1_r;
    logic [RAW_W-1:0] s2_r;
    logic [RAW_W-1:0] s3_r;
    logic [RAW_W-1:0] filt_r;
    logic [RAW_W-1:0] prev_r;
    logic [RAW_W-1:0] filt_nxt;

    assign raw = {lck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, write_data_strobe, dq};
    // A bit changes only once stages two and three agree
    assign filt_nxt = (s2_r & ~(s2_r ^ s3_r)) | (filt_r & (s2_r ^ s3_r));

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            filt_r <= '0;
            prev_r <= '0;
        end else begin
            s1_r <= raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            filt_r <= filt_nxt;
            prev_r <= filt_r;
        end
    end

    assign lnk.lck_rise = filt_r[P_LCK] & ~prev_r[P_LCK];
    assign lnk.lck_fall = ~filt_r[P_LCK] & prev_r[P_LCK];
    // Commands count only while clock enable is held
    assign lnk.cmd = filt_r[P_CKE] ? sdb_decode(filt_r[P_CS], filt_r[P_RAS], filt_r[P_CAS],
                                                filt_r[P_WE]) : CMD_NOP;
    assign lnk.ba = filt_r[P_BA +: BA_W];
    assign lnk.addr = filt_r[P_ADDR +: ADDR_W];
    assign lnk.dq = filt_r[P_DQ +: DQ_W];
    assign lnk.write_data_strobe_rise = filt_r[P_WRITE_DATA_STROBE +: LANES] & ~prev_r[P_WRITE_DATA_STROBE +: LANES];
    assign lnk.write_data_strobe_fall = ~filt_r[P_WRITE_DATA_STROBE +: LANES] & prev_r[P_WRITE_DATA_STROBE +: LANES];
endmodule

// >>> logic/sdb_pkg.sv
// Shared constants, types and helpers for the burst data path
package sdb_pkg;
    localparam int LANES = 4;
    localparam int DQ_W = 32;
    localparam int BA_W = 2;
    localparam int COL_W = 4;
    localparam int ADDR_W = 12;
    localparam int NBANK = 4;
    localparam int AUTO_PRECHARGE_SELECT_BIT = 8;
    localparam int LAT_DEPTH = 16;
    localparam int MEM_WORDS = 64;

    // Raw pin bundle bit positions inside the receive front end
    localparam int P_DQ = 0;
    localparam int P_WRITE_DATA_STROBE = 32;
    localparam int P_ADDR = 36;
    localparam int P_BA = 48;
    localparam int P_WE = 50;
    localparam int P_CAS = 51;
    localparam int P_RAS = 52;
    localparam int P_CS = 53;
    localparam int P_CKE = 54;
    localparam int P_LCK = 55;
    localparam int RAW_W = 56;

    // Register byte offsets
    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_RAS = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_RDCNT = 8'h0c;
    localparam logic [7:0] OFS_WRCNT = 8'h10;
    localparam logic [7:0] OFS_APCNT = 8'h14;

    // Field positions, values after reset and burst lengths
    localparam int CFG_CL_LSB = 0;
    localparam int CFG_WL_LSB = 4;
    localparam int CFG_BL8_BIT = 8;
    localparam logic [3:0] CL_RST = 4'h5;
    localparam logic [3:0] WL_RST = 4'h3;
    localparam logic [7:0] RAS_RST = 8'h08;
    localparam logic [3:0] BL4 = 4'h4;
    localparam logic [3:0] BL8 = 4'h8;

    typedef enum logic [2:0] {
        CMD_NOP = 3'h0,
        CMD_ACT = 3'h1,
        CMD_READ = 3'h2,
        CMD_WRITE = 3'h3,
        CMD_PRE = 3'h4
    } sdb_cmd_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_PRE = 2'b01,
        RD_BURST = 2'b11
    } sdb_rd_state_t;

    function automatic sdb_cmd_t sdb_decode(input logic cs_n, input logic ras_n,
                                            input logic cas_n, input logic we_n);
        sdb_cmd_t c;
        c = CMD_NOP;
        if (!cs_n && ras_n && !cas_n && we_n) begin
            c = CMD_READ;
        end else if (!cs_n && ras_n && !cas_n && !we_n) begin
            c = CMD_WRITE;
        end else if (!cs_n && !ras_n && cas_n && we_n) begin
            c = CMD_ACT;
        end else if (!cs_n && !ras_n && cas_n && !we_n) begin
            c = CMD_PRE;
        end
        return c;
    endfunction

    // Column of element i, wrapping inside the burst boundary
    function automatic logic [COL_W-1:0] sdb_burst_col(input logic [COL_W-1:0] col,
                                                       input logic [2:0] i,
                                                       input logic bl8);
        logic [COL_W-1:0] mask;
        logic [COL_W-1:0] sum;
        mask = bl8 ? 4'h7 : 4'h3;
        sum = col + {1'b0, i};
        return (col & ~mask) | (sum & mask);
    endfunction
endpackage

// >>> sim/sdb_ctl_model.sv
// Controller model: command pins, write strobe and write data
`timescale 1ns/100ps
module sdb_ctl_model import sdb_pkg::*; (
    // Link clocks and latency
    input wire logic lck,
    input wire logic lck90,
    input wire logic [3:0] wl,
    // Command and data pins
    output logic [3:0] cmd_n,
    output logic [BA_W-1:0] ba,
    output logic [ADDR_W-1:0] addr,
    output logic [LANES-1:0] write_data_strobe,
    output logic [DQ_W-1:0] dq
);
    int h = 0;
    logic [DQ_W-1:0] slot [int];
    // Strobe edges centred in each data half
    assign write_data_strobe = {LANES{lck90}};
    initial begin
        cmd_n = 4'hf;
        ba = '0;
        addr = '0;
    end
    // Halves outside a burst carry noise
    always @(lck) begin
        h <= h + 1;
        dq <= slot.exists(h) ? slot[h] : $urandom;
    end
    task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
                         input logic [DQ_W-1:0] d [4]);
        @(negedge lck);
        cmd_n <= c;
        ba <= b;
        addr <= a;
        if (c == 4'b0100) begin
            for (int i = 0; i < 4; i++) slot[h + 1 + 2 * wl + i] = d[i];
        end
        @(negedge lck);
        cmd_n <= 4'hf;
    endtask
endmodule

// >>> sim/sdb_gfx_burst_sva.sv
// Checker for the read side outputs
`timescale 1ns/100ps
module sdb_gfx_burst_sva import sdb_pkg::*; (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [DQ_W-1:0] DATA_PIN_DRIVE,
    input wire logic [LANES-1:0] DATA_PIN_OE_N,
    input wire logic [LANES-1:0] READ_DATA_STROBE,
    input wire logic [LANES-1:0] READ_DATA_STROBE_OE_N,
    input wire logic TERM_EN
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    sequence stb_edge;
        $changed(READ_DATA_STROBE[0]) && !READ_DATA_STROBE_OE_N[0];
    endsequence
    AST_TERM_OFF: assert property (DATA_PIN_OE_N != 4'hf |-> !TERM_EN)
        else $error("termination on during read");
    AST_DQ_LANES: assert property (DATA_PIN_OE_N inside {4'h0, 4'hf})
        else $error("data lanes enabled apart");
    AST_STB_LANES: assert property (READ_DATA_STROBE inside {4'h0, 4'hf})
        else $error("strobe lanes apart");
    AST_PREAMBLE: assert property ($fell(READ_DATA_STROBE_OE_N[0]) |->
        READ_DATA_STROBE[0])
        else $error("strobe not high at start");
    AST_IDLE: assert property (READ_DATA_STROBE_OE_N[0] |->
        !READ_DATA_STROBE[0] && DATA_PIN_OE_N[0])
        else $error("pins driven when idle");
    AST_HALF: assert property (stb_edge |=> $stable(READ_DATA_STROBE[0]) [*3])
        else $error("element shorter than half cycle");
    AST_FULL: assert property ($fell(DATA_PIN_OE_N[0]) |=> !DATA_PIN_OE_N[0] [*8])
        else $error("read burst cut short");
    AST_ALIGN: assert property (!DATA_PIN_OE_N[0] && $changed(DATA_PIN_DRIVE)
        && !$fell(DATA_PIN_OE_N[0]) |-> stb_edge)
        else $error("data moved without strobe");
endmodule
bind sdb_gfx_burst sdb_gfx_burst_sva sdb_gfx_burst_sva_i (.CLK, .RST, .DATA_PIN_DRIVE,
    .DATA_PIN_OE_N, .READ_DATA_STROBE, .READ_DATA_STROBE_OE_N, .TERM_EN);

// >>> sim/tb_sdb_gfx_burst.sv
// Self-checking bench for the burst data path
`timescale 1ns/100ps
module tb_sdb_gfx_burst;
    import sdb_pkg::*;
    logic CLK = 0, RST = 1, lck = 0, lck90 = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, cke = 1;
    logic PREADY, PSLVERR, TERM_EN, err, pstb, psoe;
    logic [7:0] PADDR = 0;
    logic [31:0] PWDATA = 0, PRDATA, drv, pdq, rd;
    logic [3:0] cmd_n, oe, soe, stb, write_data_strobe, cl, opn, wl = 4'h3;
    logic [1:0] ba, wb [4];
    logic [11:0] addr;
    logic [3:0] wc [4];
    logic [31:0] d [4], mem [int], expq [$];
    int failures = 0, compares = 0, cyc = 0;
    wire [31:0] msk = {{8{!oe[3]}}, {8{!oe[2]}}, {8{!oe[1]}}, {8{!oe[0]}}};
    wire [31:0] pin = (pdq & ~msk) | (drv & msk);
    initial forever #4 CLK = ~CLK;
    initial #3.3 forever #32 lck = ~lck;
    initial #19.3 forever #32 lck90 = ~lck90;
    sdb_gfx_burst sdb_gfx_burst_i (.CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
        .PRDATA, .PREADY, .PSLVERR, .LINK_CLK(lck), .CKE(cke), .CS_N(cmd_n[3]),
        .RAS_N(cmd_n[2]), .CAS_N(cmd_n[1]), .WE_N(cmd_n[0]), .BA(ba), .CMD_ADDR(addr),
        .DATA_PIN_SENSE(pin), .DATA_PIN_DRIVE(drv), .DATA_PIN_OE_N(oe),
        .READ_DATA_STROBE(stb), .READ_DATA_STROBE_OE_N(soe), .WRITE_DATA_STROBE(write_data_strobe),
        .TERM_EN);
    sdb_ctl_model sdb_ctl_model_i (.lck, .lck90, .wl, .cmd_n, .ba, .addr, .write_data_strobe, .dq(pdq));
    function automatic logic [5:0] key(input logic [1:0] b, input logic [3:0] c, input int j);
        logic [3:0] s;
        s = c + j[3:0];
        return {b, c[3:2], s[1:0]};
    endfunction
    task automatic ck(input string n, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        PSEL <= 1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CLK);
        PENABLE <= 1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 0;
        PENABLE <= 0;
        @(posedge CLK);
    endtask
    task automatic give_verdict;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 8000) begin
            failures++;
            give_verdict;
        end
    end
    // Each strobe edge inside a driven burst carries one element
    always @(negedge CLK) begin
        if (stb[0] !== pstb && psoe === 1'b0 && soe[0] === 1'b0)
            ck("read data", expq.pop_front(), drv);
        pstb = stb[0];
        psoe = soe[0];
    end
    initial begin
        void'($urandom(13));
        repeat (3) @(posedge CLK);
        RST <= 0;
        @(posedge CLK);
        apb(0, OFS_RAS, 0);
        ck("ras reset", {24'h0, RAS_RST}, rd);
        cl = 4'(3 + $urandom_range(3));
        wl = 4'(2 + $urandom_range(2));
        apb(1, OFS_CFG, {24'h0, wl, cl});
        apb(0, OFS_CFG, 0);
        ck("cfg", {24'h0, wl, cl}, rd);
        apb(0, 8'h40, 0);
        ck("unmapped", 1, {31'h0, err});
        for (int b = 0; b < NBANK; b++) sdb_ctl_model_i.issue(4'b0011, b[1:0], 12'h0, d);
        repeat (4) @(negedge lck);
        for (int i = 0; i < 4; i++) begin
            wb[i] = 2'($urandom_range(3));
            wc[i] = 4'($urandom_range(15));
            for (int j = 0; j < 4; j++) begin
                d[j] = $urandom;
                mem[key(wb[i], wc[i], j)] = d[j];
            end
            sdb_ctl_model_i.issue(4'b0100, wb[i], {8'h0, wc[i]}, d);
        end
        repeat (6) @(negedge lck);
        for (int i = 0; i < 4; i++) begin
            for (int j = 0; j < 4; j++) expq.push_back(mem[key(wb[i], wc[i], j)]);
            sdb_ctl_model_i.issue(4'b0101, wb[i], {3'h0, i == 3, 4'h0, wc[i]}, d);
        end
        repeat (30) @(negedge lck);
        @(posedge CLK);
        ck("elements left", 0, expq.size());
        apb(0, OFS_RDCNT, 0);
        ck("reads done", 4, rd);
        apb(0, OFS_WRCNT, 0);
        ck("writes done", 4, rd);
        apb(0, OFS_APCNT, 0);
        ck("auto precharges", 1, rd);
        // Write with auto precharge, then precharges with clock enable low and high
        sdb_ctl_model_i.issue(4'b0100, wb[0], 12'h100, d);
        repeat (8) @(negedge lck);
        cke <= 0;
        sdb_ctl_model_i.issue(4'b0010, 2'h0, 12'h100, d);
        cke <= 1;
        sdb_ctl_model_i.issue(4'b0010, ~wb[0], 12'h0, d);
        repeat (2) @(negedge lck);
        @(posedge CLK);
        opn = 4'hf & ~(4'h1 << wb[3]) & ~(4'h1 << wb[0]) & ~(4'h1 << ~wb[0]);
        apb(0, OFS_STAT, 0);
        ck("status", {25'h0, 3'h4, opn}, rd);
        apb(0, OFS_APCNT, 0);
        ck("auto precharges", 2, rd);
        give_verdict;
    end
endmodule
